// [verilog/pin_channel_switch_control.sv]
/*
 Pin channel switch controller: decodes 24-bit serial instructions
 into per-channel switch bits, gates driver and comparator switches by
 the open-channel pins, refuses calibration during continuity tests,
 answers serial readback and offers a Wishbone status/control port.
 Assumes all inputs synchronous to clk_sys, serial clock much slower.
*/
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
module pin_channel_switch_control
    import pin_switch_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic chipRst_n,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    input wire logic load,
    output logic serial_out,
    input wire logic [NUM_CH-1:0] open_channel_input,
    input wire logic [NUM_CH-1:0] compare_a_output,
    input wire logic [NUM_CH-1:0] compare_b_output,
    output logic [NUM_CH-1:0] driver_output_switch,
    output logic [NUM_CH-1:0] comparator_input_switch,
    output logic [NUM_CH-1:0] pmu_force_sense_switch,
    output logic [NUM_CH-1:0] continuity_switch,
    output logic calStart,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // Chip pin reset and system reset both clear everything
    wire anyRst = sys_rst | ~chipRst_n;

    instr_t ins;
    logic insValid;
    sw_t [NUM_CH-1:0] sw_r;
    logic [NUM_CH-1:0][NUM_SETS-1:0] member_r;
    logic [7:0] calGen_r;
    logic calRefused_r;
    logic calStart_r;
    logic [31:0] ctrl_r;
    logic [NUM_CH-1:0] drvEff_r;
    logic [NUM_CH-1:0] compEff_r;
    logic [NUM_CH-1:0] pmuEff_r;
    logic [NUM_CH-1:0] contEff_r;
    logic rbStart_r;
    logic [INSTR_W-1:0] rbFrame_r;
    logic ack_r;
    logic [31:0] rdData_r;
    logic wbClrRefused;

    serial_link_shifter u_shift (
        .clk_sys(clk_sys),
        .anyRst(anyRst),
        .serial_clock_in(serial_clock_in),
        .serial_in(serial_in),
        .loadIn(load),
        .loadBlock(ctrl_r[CTRL_LOAD_BLOCK]),
        .rbStart(rbStart_r),
        .rbFrame(rbFrame_r),
        .instrOut(ins),
        .instrValid(insValid),
        .serial_out(serial_out)
    );

    // Does an instruction address this channel, directly or via a set
    function automatic logic chanHit(input instr_t i, input logic [NUM_SETS-1:0] mem,
                                     input logic [1:0] ch);
        logic hit;
        hit = 1'b0;
        if (i.sel == SEL_SET)
            hit = !i.addr[3] && mem[i.addr[2:0]];
        else
            hit = (i.addr == {2'b00, ch});
        return hit;
    endfunction

    // Build the readback frame: idle lead bits, data, zero tail
    function automatic logic [INSTR_W-1:0] frameOf(input logic [DATA_W-1:0] d);
        return {{RB_LEAD{1'b0}}, d, {RB_TAIL{1'b0}}};
    endfunction

    // Field decode of the latched instruction
    wire isChip = (ins.mode == MODE_CHIP);
    wire isRead = (ins.rd == RD_READ);
    wire doWrite = insValid && !isRead;
    wire doRead = insValid && isRead;
    wire chipReset = doWrite && isChip && (ins.func == FN_SOFT_RESET);
    wire calReq = doWrite && isChip && (ins.func == FN_CALIBRATE);
    wire chSwWr = doWrite && !isChip && (ins.func == FN_SWITCHES);
    wire chSetWr = doWrite && !isChip && (ins.func == FN_SET_MEMBER);
    wire anyContClosed = |contEff_r;
    wire calAccept = calReq && !anyContClosed;
    wire calDeny = calReq && anyContClosed;

    // Per-channel address hits
    wire [NUM_CH-1:0] hit;
    assign hit[0] = chanHit(ins, member_r[0], 2'd0);
    assign hit[1] = chanHit(ins, member_r[1], 2'd1);
    assign hit[2] = chanHit(ins, member_r[2], 2'd2);
    assign hit[3] = chanHit(ins, member_r[3], 2'd3);

    // Readback value for a direct channel read; set reads answer zero
    wire [1:0] rdCh = ins.addr[1:0];
    wire rdChValid = (ins.sel != SEL_SET) && (ins.addr[3:2] == 2'b00);
    wire [DATA_W-1:0] chSwRb = {7'h00, compare_b_output[rdCh],
                                compare_a_output[rdCh], sw_r[rdCh]};
    wire [DATA_W-1:0] chSetRb = {5'h00, member_r[rdCh]};
    wire [DATA_W-1:0] chipRb = (ins.func == FN_IDENT) ? CHIP_IDENT
                             : (ins.func == FN_CALIBRATE) ? {4'h0, calRefused_r, calGen_r}
                             : '0;
    wire [DATA_W-1:0] chanRb = !rdChValid ? '0
                             : (ins.func == FN_SWITCHES) ? chSwRb
                             : (ins.func == FN_SET_MEMBER) ? chSetRb
                             : '0;
    wire [DATA_W-1:0] rbData = isChip ? chipRb : chanRb;

    // Stored switch bits; the data field carries them in its low bits
    always_ff @(posedge clk_sys or posedge anyRst)
    begin
        if (anyRst)
            sw_r <= '0;
        else if (chipReset)
            sw_r <= '0;
        else
            for (int c = 0; c < NUM_CH; c++)
                if (chSwWr && hit[c])
                    sw_r[c] <= sw_t'(ins.data[3:0]);
    end

    // Set membership, one byte per channel
    always_ff @(posedge clk_sys or posedge anyRst)
    begin
        if (anyRst)
            member_r <= '0;
        else if (chipReset)
            member_r <= '0;
        else
            for (int c = 0; c < NUM_CH; c++)
                if (chSetWr && ins.sel != SEL_SET && hit[c])
                    member_r[c] <= ins.data[NUM_SETS-1:0];
    end

    // Calibration: generation count stands in for stored values
    always_ff @(posedge clk_sys or posedge anyRst)
    begin
        if (anyRst)
        begin
            calGen_r <= 8'h00;
            calRefused_r <= 1'b0;
            calStart_r <= 1'b0;
        end
        else
        begin
            calStart_r <= calAccept;
            if (calAccept)
                calGen_r <= calGen_r + 8'h01;
            // Hardware set wins over software clear
            if (calDeny)
                calRefused_r <= 1'b1;
            else if (wbClrRefused || chipReset)
                calRefused_r <= 1'b0;
        end
    end

    // Effective switch drives; open-channel never forces a close
    always_ff @(posedge clk_sys or posedge anyRst)
    begin
        if (anyRst)
        begin
            drvEff_r <= '0;
            compEff_r <= '0;
            pmuEff_r <= '0;
            contEff_r <= '0;
        end
        else
            for (int c = 0; c < NUM_CH; c++)
            begin
                drvEff_r[c] <= sw_r[c].drv & ~open_channel_input[c];
                compEff_r[c] <= sw_r[c].comp & ~open_channel_input[c];
                pmuEff_r[c] <= sw_r[c].pmu;
                contEff_r[c] <= sw_r[c].cont;
            end
    end

    // Readback request to the shifter, one cycle after the latch
    always_ff @(posedge clk_sys or posedge anyRst)
    begin
        if (anyRst)
        begin
            rbStart_r <= 1'b0;
            rbFrame_r <= '0;
        end
        else
        begin
            rbStart_r <= doRead;
            if (doRead)
                rbFrame_r <= frameOf(rbData);
        end
    end

    // Wishbone decode; unmapped addresses ack and read zero
    wire wbReq = wb_cyc_i && wb_stb_i && !ack_r;
    wire wbWr = wbReq && wb_we_i;
    wire ctrlWr = wbWr && (wb_adr_i == REG_CTRL) && wb_sel_i[0];
    assign wbClrRefused = ctrlWr && wb_dat_i[CTRL_CLR_REFUSED];
    wire [15:0] storedBits = {sw_r[3], sw_r[2], sw_r[1], sw_r[0]};
    wire [15:0] effBits = {contEff_r, pmuEff_r, compEff_r, drvEff_r};
    wire [31:0] rdMux = (wb_adr_i == REG_CTRL) ? ctrl_r
                      : (wb_adr_i == REG_STORED) ? {16'h0000, storedBits}
                      : (wb_adr_i == REG_EFFECTIVE) ? {16'h0000, effBits}
                      : (wb_adr_i == REG_CAL) ? {23'h000000, calRefused_r, calGen_r}
                      : 32'h0000_0000;

    // Control register: only the load-block bit is stored
    always_ff @(posedge clk_sys or posedge anyRst)
    begin
        if (anyRst)
            ctrl_r <= CTRL_RESET;
        else if (ctrlWr)
            ctrl_r[CTRL_LOAD_BLOCK] <= wb_dat_i[CTRL_LOAD_BLOCK];
    end

    // One-cycle answer; ack drops the cycle after it was given
    always_ff @(posedge clk_sys or posedge anyRst)
    begin
        if (anyRst)
        begin
            ack_r <= 1'b0;
            rdData_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= wbReq;
            if (wbReq && !wb_we_i)
                rdData_r <= rdMux;
        end
    end

    // Outputs, all from flip-flops
    assign driver_output_switch = drvEff_r;
    assign comparator_input_switch = compEff_r;
    assign pmu_force_sense_switch = pmuEff_r;
    assign continuity_switch = contEff_r;
    assign calStart = calStart_r;
    assign wb_dat_o = rdData_r;
    assign wb_ack_o = ack_r;
endmodule

// [verilog/pin_switch_pkg.sv]
/*
 Constants, instruction layout and register map for the pin channel
 switch controller. Assumes a single clk_sys domain and a 32-bit
 classic Wishbone slave port.
*/
// Overview of operation
// - Comparator switch closes on control bit 1, opens on 0.
// - High open-channel input forces comparator switch open; low never forces closed.
// - High open-channel input also forces driver output switch open.
// - Measurement force/sense switch per channel follows its bit, normally open.
// - Continuity switch normally open, closes only when its bit is programmed 1.
// - Calibration refused, values kept, while any continuity switch is closed.
// - Both comparator outputs of a channel readable by serial read.
// - Every instruction is 24 bits of function, read, mode, address, select, data.
// - Thirteen-bit data field carries the value to write.
// - Select bit 0 addresses one channel, 1 addresses a set.
// - Four-bit address field names the channel or set.
// - Mode bit 0 is a chip function, 1 a channel or set function.
// - Read bit 0 writes a register, 1 reads it back.
// - Four-bit function field selects the function written or read.
// - Input sampled on serial clock rise; output changes on its fall.
// - Load high at the 24th rise latches the instruction for decode.
package pin_switch_pkg;
    localparam int NUM_CH = 4;
    localparam int NUM_SETS = 8;
    localparam int INSTR_W = 24;
    localparam int DATA_W = 13;
    localparam int RB_LEAD = 5;
    localparam int RB_TAIL = 6;
    localparam logic [4:0] RB_COUNT = 5'h18;

    // Instruction word, most significant field first
    typedef struct packed {
        logic [3:0] func;
        logic rd;
        logic mode;
        logic [3:0] addr;
        logic sel;
        logic [DATA_W-1:0] data;
    } instr_t;

    // Per-channel switch control bits, bit 3 downward
    typedef struct packed {
        logic cont;
        logic pmu;
        logic comp;
        logic drv;
    } sw_t;

    localparam logic MODE_CHIP = 1'b0;
    localparam logic SEL_SET = 1'b1;
    localparam logic RD_READ = 1'b1;

    // Chip function codes
    localparam logic [3:0] FN_SOFT_RESET = 4'h0;
    localparam logic [3:0] FN_CALIBRATE = 4'h1;
    localparam logic [3:0] FN_IDENT = 4'h2;
    // Channel and set function codes
    localparam logic [3:0] FN_SWITCHES = 4'h1;
    localparam logic [3:0] FN_SET_MEMBER = 4'h2;

    localparam logic [DATA_W-1:0] CHIP_IDENT = 13'h0a5; // Arbitrary value

    // Wishbone register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STORED = 8'h04;
    localparam logic [7:0] REG_EFFECTIVE = 8'h08;
    localparam logic [7:0] REG_CAL = 8'h0c;

    // Control register fields
    localparam int CTRL_LOAD_BLOCK = 0;
    localparam int CTRL_CLR_REFUSED = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage

// [verilog/serial_link_shifter.sv]
/*
 Serial shift path: input shift register, instruction latch, echo
 output and readback shifter. Assumes serial clock, data and load are
 synchronous to clk_sys and run far slower than it.
*/
`timescale 1ns/1ps
module serial_link_shifter
    import pin_switch_pkg::*;
(
    input wire logic clk_sys,
    input wire logic anyRst,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    input wire logic loadIn,
    input wire logic loadBlock,
    input wire logic rbStart,
    input wire logic [INSTR_W-1:0] rbFrame,
    output pin_switch_pkg::instr_t instrOut,
    output logic instrValid,
    output logic serial_out
);
    logic sclkPrev_r;
    logic [INSTR_W-1:0] shift_r;
    logic [INSTR_W-1:0] rb_r;
    logic [4:0] rbCnt_r;
    logic outBit_r;
    instr_t instr_r;
    logic valid_r;

    wire sclkRise = serial_clock_in & ~sclkPrev_r;
    wire sclkFall = ~serial_clock_in & sclkPrev_r;
    wire [INSTR_W-1:0] shiftNxt = {shift_r[INSTR_W-2:0], serial_in};
    wire rbActive = (rbCnt_r != 5'h00);

    // Shift in on rise, latch on rise with load high
    always_ff @(posedge clk_sys or posedge anyRst)
    begin
        if (anyRst)
        begin
            sclkPrev_r <= 1'b0;
            shift_r <= '0;
            instr_r <= '0;
            valid_r <= 1'b0;
        end
        else
        begin
            sclkPrev_r <= serial_clock_in;
            valid_r <= 1'b0;
            if (sclkRise)
                shift_r <= shiftNxt;
            if (sclkRise && loadIn && !loadBlock)
            begin
                instr_r <= instr_t'(shiftNxt);
                valid_r <= 1'b1;
            end
        end
    end

    // Output changes only on fall: echo delayed 24 rises, or readback
    always_ff @(posedge clk_sys or posedge anyRst)
    begin
        if (anyRst)
        begin
            rb_r <= '0;
            rbCnt_r <= 5'h00;
            outBit_r <= 1'b0;
        end
        else if (rbStart)
        begin
            rb_r <= rbFrame;
            rbCnt_r <= RB_COUNT;
        end
        else if (sclkFall)
        begin
            outBit_r <= rbActive ? rb_r[INSTR_W-1] : shift_r[INSTR_W-1];
            if (rbActive)
            begin
                rb_r <= {rb_r[INSTR_W-2:0], 1'b0};
                rbCnt_r <= rbCnt_r - 5'h01;
            end
        end
    end

    assign instrOut = instr_r;
    assign instrValid = valid_r;
    assign serial_out = outBit_r;
endmodule

// [testbench/pin_channel_switch_control_assertions.sv]
/*
 Port-level checks on the pin channel switch controller.
 Assumes one clk_sys domain and a serial clock phase far longer than three cycles.
*/
`timescale 1ns/1ps
module pin_channel_switch_control_checker
    import pin_switch_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic chipRst_n,
    input wire logic serial_clock_in,
    input wire logic serial_out,
    input wire logic [NUM_CH-1:0] open_channel_input,
    input wire logic [NUM_CH-1:0] driver_output_switch,
    input wire logic [NUM_CH-1:0] comparator_input_switch,
    input wire logic [NUM_CH-1:0] pmu_force_sense_switch,
    input wire logic [NUM_CH-1:0] continuity_switch,
    input wire logic calStart,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking @(posedge clk_sys);
    endclocking
    // Either reset source silences every check but a_reset_opens_all
    default disable iff (sys_rst || !chipRst_n);

    // Bus request and its one-cycle answer
    sequence wbTaken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ackPulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_ack_one_cycle: assert property (wbTaken |=> ackPulse)
        else $error("bus answer not a one-cycle ack");
    a_comp_forced_open: assert property ((comparator_input_switch & $past(open_channel_input)) == 4'h0)
        else $error("comparator switch closed under open-channel");
    a_drv_forced_open: assert property ((driver_output_switch & $past(open_channel_input)) == 4'h0)
        else $error("driver switch closed under open-channel");
    a_reset_opens_all: assert property (disable iff (1'b0) (sys_rst || !chipRst_n) |-> {driver_output_switch, comparator_input_switch, pmu_force_sense_switch, continuity_switch} == 16'h0000)
        else $error("switch closed during reset");
    a_cal_refused: assert property (($past(|continuity_switch) && |continuity_switch) |-> !calStart)
        else $error("calibration started with continuity closed");
    a_cal_single: assert property (calStart |=> !calStart)
        else $error("calibration start longer than one cycle");
    // Slow serial clock, so an output change always follows a low sample
    a_out_on_fall: assert property ($changed(serial_out) |-> !$past(serial_clock_in))
        else $error("serial output moved outside a falling phase");
    a_cont_by_serial: assert property ($changed(continuity_switch) |-> serial_clock_in)
        else $error("continuity switch moved without serial load");
    a_pmu_by_serial: assert property ($changed(pmu_force_sense_switch) |-> serial_clock_in)
        else $error("measurement switch moved without serial load");
endmodule

bind pin_channel_switch_control pin_channel_switch_control_checker chk_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .chipRst_n(chipRst_n),
    .serial_clock_in(serial_clock_in), .serial_out(serial_out),
    .open_channel_input(open_channel_input), .driver_output_switch(driver_output_switch),
    .comparator_input_switch(comparator_input_switch),
    .pmu_force_sense_switch(pmu_force_sense_switch), .continuity_switch(continuity_switch),
    .calStart(calStart), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o)
);

// [testbench/serial_ctrl_model.sv]
/*
 Behavioural tester control logic on the serial programming link.
 Assumes the bench calls send and that clk_sys is shared with the device.
*/
`timescale 1ns/1ps
module serial_ctrl_model
(
    input wire logic clk_sys,
    input wire logic serial_out,
    output logic serial_clock_in,
    output logic serial_in,
    output logic load
);
    localparam int PHASE = 8; // Well above the three-cycle minimum phase

    // Link clock stands still between frames
    initial
    begin
        serial_clock_in = 1'h0;
        serial_in = 1'h0;
        load = 1'h0;
    end

    // One frame out, collecting what the device returns meanwhile
    task automatic send(input logic [23:0] w, output logic [23:0] rb);
        for (int i = 23; i >= 0; i--)
        begin
            @(posedge clk_sys);
            serial_in <= w[i];
            load <= (i == 0);
            repeat (PHASE) @(posedge clk_sys);
            rb[i] = serial_out; // Settled since the previous fall
            serial_clock_in <= 1'h1;
            repeat (PHASE) @(posedge clk_sys);
            serial_clock_in <= 1'h0;
        end
        @(posedge clk_sys);
        load <= 1'h0;
    endtask
endmodule

// [testbench/pin_channel_switch_control_test.sv]
/*
 Self-checking bench for the pin channel switch controller.
 Assumes the serial partner model and a bound port checker.
*/
`timescale 1ns/1ps
module pin_channel_switch_control_test;
    import pin_switch_pkg::*;
    logic clk_sys, sys_rst, chipRst_n, serial_clock_in, serial_in, load, serial_out;
    logic [NUM_CH-1:0] open_channel_input, compare_a_output, compare_b_output;
    logic [NUM_CH-1:0] drvSw, compSw, pmuSw, contSw;
    logic calStart, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [23:0] rb;
    int fails, samplesChecked, cycles, calPulses;

    pin_channel_switch_control pin_channel_switch_control_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .chipRst_n(chipRst_n),
        .serial_clock_in(serial_clock_in), .serial_in(serial_in), .load(load),
        .serial_out(serial_out), .open_channel_input(open_channel_input),
        .compare_a_output(compare_a_output), .compare_b_output(compare_b_output),
        .driver_output_switch(drvSw), .comparator_input_switch(compSw),
        .pmu_force_sense_switch(pmuSw), .continuity_switch(contSw), .calStart(calStart),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
    );
    serial_ctrl_model serial_ctrl_model_i (
        .clk_sys(clk_sys), .serial_out(serial_out), .serial_clock_in(serial_clock_in),
        .serial_in(serial_in), .load(load)
    );

    // 200 MHz system clock
    initial
    begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Hang guard, roughly five times the expected run
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (calStart === 1'h1) calPulses <= calPulses + 1;
        if (cycles == 30000)
        begin
            fails++;
            wrapUp();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrapUp();
        $display("Checks %0d, mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Classic single cycle; request held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask

    // One instruction, then room for decode
    task automatic ins(input logic [3:0] f, input logic r, input logic m,
        input logic [3:0] a, input logic s, input logic [12:0] d);
        serial_ctrl_model_i.send({f, r, m, a, s, d}, rb);
        repeat (6) @(posedge clk_sys);
    endtask

    // Nibbles: driver, comparator, measurement, continuity
    function automatic logic [31:0] sw();
        return {16'h0000, drvSw, compSw, pmuSw, contSw};
    endfunction

    initial
    begin
        {sys_rst, chipRst_n, open_channel_input, compare_a_output, compare_b_output} = 14'h3000;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {43'h0, 4'hf};
        {fails, samplesChecked, cycles, calPulses} = '0;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'h0;
        repeat (2) @(posedge clk_sys);
        check(sw(), 32'h0);
        wb(1'h0, REG_CTRL, 32'h0);
        check(rd, CTRL_RESET);
        // Continuity on channel 0 with its driver left open
        ins(FN_SWITCHES, 1'h0, 1'h1, 4'h0, 1'h0, 13'h00e);
        ins(FN_SWITCHES, 1'h0, 1'h1, 4'h2, 1'h0, 13'h003);
        check(sw(), 32'h4511);
        wb(1'h0, REG_STORED, 32'h0);
        check(rd, 32'h030e);
        // Open-channel overrides without touching stored bits
        open_channel_input <= 4'h4;
        repeat (3) @(posedge clk_sys);
        check(sw(), 32'h0111);
        wb(1'h0, REG_STORED, 32'h0);
        check(rd, 32'h030e);
        open_channel_input <= 4'h0;
        repeat (3) @(posedge clk_sys);
        check(sw(), 32'h4511);
        // Calibration refused while continuity is closed, then accepted
        ins(FN_CALIBRATE, 1'h0, MODE_CHIP, 4'h0, 1'h0, 13'h0);
        wb(1'h0, REG_CAL, 32'h0);
        check(rd, 32'h0100);
        ins(FN_SWITCHES, 1'h0, 1'h1, 4'h0, 1'h0, 13'h006);
        wb(1'h1, REG_CTRL, 32'h2);
        ins(FN_CALIBRATE, 1'h0, MODE_CHIP, 4'h0, 1'h0, 13'h0);
        wb(1'h0, REG_CAL, 32'h0);
        check(rd, 32'h0001);
        check(calPulses, 32'h1);
        // Readback of channel 0 with comparator B high
        compare_b_output <= 4'h1;
        ins(FN_SWITCHES, RD_READ, 1'h1, 4'h0, 1'h0, 13'h1fff);
        ins(FN_SWITCHES, 1'h0, 1'h1, 4'h1, 1'h0, 13'h0);
        check(rb, {5'h0, 13'h026, 6'h0});
        // Channel 3 joins set 0; set 1 must miss it
        ins(FN_SET_MEMBER, 1'h0, 1'h1, 4'h3, 1'h0, 13'h001);
        // Echo after readback: the previous word comes back whole
        check(rb, {FN_SWITCHES, 1'h0, 1'h1, 4'h1, 1'h0, 13'h000});
        ins(FN_SWITCHES, 1'h0, 1'h1, 4'h0, SEL_SET, 13'h001);
        ins(FN_SWITCHES, 1'h0, 1'h1, 4'h1, SEL_SET, 13'h002);
        check(sw(), 32'hc510);
        // Blocked load, then an unmapped address
        wb(1'h1, REG_CTRL, 32'h1);
        ins(FN_SWITCHES, 1'h0, 1'h1, 4'h1, 1'h0, 13'h003);
        check(sw(), 32'hc510);
        wb(1'h0, REG_CTRL, 32'h0);
        check(rd, 32'h1);
        wb(1'h1, REG_CTRL, 32'h0);
        wb(1'h0, 8'h40, 32'h0);
        check(rd, 32'h0);
        // Chip ident read, collected while the soft reset shifts in
        ins(FN_IDENT, RD_READ, MODE_CHIP, 4'h0, 1'h0, 13'h0);
        ins(FN_SOFT_RESET, 1'h0, MODE_CHIP, 4'h0, 1'h0, 13'h0);
        check(rb, {5'h0, CHIP_IDENT, 6'h0});
        check(sw(), 32'h0);
        // Reset pin clears without any serial clock edge
        ins(FN_SWITCHES, 1'h0, 1'h1, 4'h1, 1'h0, 13'h002);
        check(sw(), 32'h0200);
        chipRst_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        check(sw(), 32'h0);
        chipRst_n <= 1'h1;
        repeat (2) @(posedge clk_sys);
        wrapUp();
    end
endmodule
